// ===== include/pcg_pkg.sv
// shared constants, types and decode for the paired channel gate block
`default_nettype none
package pcg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int NPIN   = 6;
	localparam int NEVT   = 3;

	// register offsets
	localparam logic [7:0] OFF_FUNC   = 8'h00;
	localparam logic [7:0] OFF_ENABLE = 8'h04;
	localparam logic [7:0] OFF_TRIG   = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_MASK   = 8'h10;
	localparam logic [7:0] OFF_MODE   = 8'h14;

	// values after reset and standby
	localparam logic [7:0] RST_FUNC   = 8'hC0;
	localparam logic [7:0] RST_ENABLE = 8'hFF;
	localparam logic       RST_XOFF   = 1'b1;

	// field positions
	localparam int FC_CMB_LO  = 4;
	localparam int FC_CMB_HI  = 5;
	localparam int FC_BUF_A3  = 0;
	localparam int FC_BUF_B3  = 1;
	localparam int FC_BUF_A4  = 2;
	localparam int FC_BUF_B4  = 3;
	localparam int TRIG_XOFF  = 4;
	localparam int EV_SHUT    = 0;
	localparam int EV_IGNORED = 1;
	localparam int EV_CLASH   = 2;
	// pin index equals its gate bit in the master enable register
	localparam int PIN_CH3_A  = 0;
	localparam int PIN_CH4_A  = 1;
	localparam int PIN_CH4_B  = 2;
	localparam int PIN_CH3_B  = 3;
	localparam int PIN_CMP_A  = 4;
	localparam int PIN_CMP_B  = 5;

	typedef enum logic [1:0] {PCG_NORMAL, PCG_COMP, PCG_RSYNC} pcg_mode_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} pcg_bus_t;

	// one pin request: drive enable and level
	typedef struct packed {
		logic oe;
		logic out;
	} pcg_pin_t;

	// combination field: 01 falls back to normal operation
	function automatic pcg_mode_t pcg_decode(input logic [1:0] cmb);
		case (cmb)
			2'b10:   pcg_decode = PCG_COMP;
			2'b11:   pcg_decode = PCG_RSYNC;
			default: pcg_decode = PCG_NORMAL;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== src/pcg_pin_gate.sv
// one output pin: timer drive gated by its master enable, else gpio
`default_nettype none
module pcg_pin_gate (
	input  wire logic            mclk,
	input  wire logic            reset_n,
	input  wire logic            gate,
	input  wire pcg_pkg::pcg_pin_t timer,
	input  wire pcg_pkg::pcg_pin_t gpio,
	output var  logic            pin_out,
	output var  logic            pin_oe
);
	import pcg_pkg::*;

	logic timer_owns;
	// a cleared gate hands the pin back to gpio whatever the timer wants
	assign timer_owns = gate && timer.oe;

	// registered pin drive so the pad sees no decode glitches
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end else begin
			pin_out <= timer_owns ? timer.out : gpio.out;
			pin_oe  <= timer_owns ? 1'b1 : gpio.oe;
		end
	end
endmodule
`default_nettype wire

// ===== src/pcg_irq.sv
// sticky event status, mask and level interrupt
`default_nettype none
module pcg_irq #(
	parameter int W = 3
) (
	input  wire logic         mclk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] event_in,
	input  wire logic         clr_wr,
	input  wire logic         mask_wr,
	input  wire logic [W-1:0] wdata,
	output var  logic [W-1:0] status,
	output var  logic [W-1:0] mask,
	output var  logic         irq
);
	import pcg_pkg::*;

	logic [W-1:0] next_status;
	// set beats clear so an event in the clearing cycle survives
	always_comb begin
		next_status = status;
		if (clr_wr)
			next_status = next_status & ~wdata;
		next_status = next_status | event_in;
	end

	// status bits, write one to clear
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			status <= '0;
		else
			status <= next_status;
	end

	// mask, one enables the matching status bit
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			mask <= '0;
		else if (mask_wr)
			mask <= wdata;
	end

	// registered level from the next status, so it changes on the same edge as the status
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			irq <= 1'b0;
		else
			irq <= |(next_status & (mask_wr ? wdata : mask));
	end
endmodule
`default_nettype wire

// ===== src/pcg_gate.sv
// paired channel mode control and master output gate, top level
// Summary of operation
// - function control is 8-bit read/write, reset and standby load C0
// - top two bits of both registers are read-only ones
// - combination field 00 normal, 10 complementary, 11 reset-synchronized
// - paired modes override the per-channel pwm bits of channels 3, 4
// - sync bits of channels 3 and 4 stay valid in paired modes
// - bits 3..0 put ch4 B, ch4 A, ch3 B, ch3 A behind shadows
// - master enable is 8-bit read/write, reset and standby load FF
// - enable bit 5 low releases ch4 complementary B pin to gpio
// - enable bit 4 low releases ch4 complementary A pin to gpio
// - enable bit 3 low releases ch3 B pin to gpio
// - capture A of ch1 clears complementary and ch3 B enables
// - master enable gates all six ch3 and ch4 output pins
// - bits 2..0 gate ch4 B, ch4 A, ch3 A, same trigger clears them
// - trigger acts only when enabled and in a paired mode, resets off
//
// Decided for this implementation: the strobed register port and the register offsets.
`default_nettype none
module pcg_gate (
	input  wire logic                               mclk,
	input  wire logic                               reset_n,
	input  wire logic                               standby,
	input  wire pcg_pkg::pcg_bus_t                  bus,
	output var  logic [pcg_pkg::DATA_W-1:0]         rdata,
	input  wire logic                               capture_a_ch1,
	input  wire logic                               ch3_single_pwm,
	input  wire logic                               ch4_single_pwm,
	input  wire logic                               ch3_sync_op,
	input  wire logic                               ch4_sync_op,
	input  wire pcg_pkg::pcg_pin_t [pcg_pkg::NPIN-1:0] timer_pin,
	input  wire pcg_pkg::pcg_pin_t [pcg_pkg::NPIN-1:0] gpio_pin,
	output var  logic [pcg_pkg::NPIN-1:0]           pin_out,
	output var  logic [pcg_pkg::NPIN-1:0]           pin_oe,
	output var  logic                               mode_comp,
	output var  logic                               mode_rsync,
	output var  logic                               ch3_pwm_on,
	output var  logic                               ch4_pwm_on,
	output var  logic                               ch3_sync_on,
	output var  logic                               ch4_sync_on,
	output var  logic [3:0]                         buffer_on,
	output var  logic                               irq
);
	import pcg_pkg::*;

	logic [7:0]      pair_function_control;
	logic [7:0]      output_master_enable;
	logic            ext_trigger_off;
	logic [NEVT-1:0] irq_status;
	logic [NEVT-1:0] irq_mask;
	logic [NEVT-1:0] event_vec;
	logic            wr_func;
	logic            wr_enable;
	logic            wr_trig;
	logic            wr_status;
	logic            wr_mask;
	logic            paired;
	logic            trigger_hit;
	logic            sync_clash;
	logic            clash_q;
	pcg_mode_t       cur_mode;
	logic [7:0]      next_rdata;
	logic [7:0]      mode_word;

	// write decode, one strobe per writable register, none for the read-only mode view
	assign wr_func   = bus.wr && (bus.addr == OFF_FUNC);
	assign wr_enable = bus.wr && (bus.addr == OFF_ENABLE);
	assign wr_trig   = bus.wr && (bus.addr == OFF_TRIG);
	assign wr_status = bus.wr && (bus.addr == OFF_STATUS);
	assign wr_mask   = bus.wr && (bus.addr == OFF_MASK);

	// mode follows the stored field; 01 reads back but acts as normal
	assign cur_mode = pcg_decode(pair_function_control[FC_CMB_HI:FC_CMB_LO]);
	assign paired   = (cur_mode != PCG_NORMAL);

	// capture A shuts the outputs only when enabled and paired
	assign trigger_hit = capture_a_ch1 && !ext_trigger_off && paired;

	// both channels synchronised in complementary mode is a software fault
	assign sync_clash = (cur_mode == PCG_COMP) && ch3_sync_op && ch4_sync_op;

	// function control; standby reinitialises like a reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			pair_function_control <= RST_FUNC;
		else if (standby)
			pair_function_control <= RST_FUNC;
		else if (wr_func)
			pair_function_control <= {2'b11, bus.wdata[5:0]};
	end

	// master enable; the trigger clear is applied last so it wins
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			output_master_enable <= RST_ENABLE;
		end else if (standby) begin
			output_master_enable <= RST_ENABLE;
		end else begin
			if (wr_enable)
				output_master_enable <= {2'b11, bus.wdata[5:0]};
			if (trigger_hit)
				output_master_enable[5:0] <= 6'h00;
		end
	end

	// trigger control; only the disable bit is stored
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			ext_trigger_off <= RST_XOFF;
		else if (standby)
			ext_trigger_off <= RST_XOFF;
		else if (wr_trig)
			ext_trigger_off <= bus.wdata[TRIG_XOFF];
	end

	// edge of the sync clash so it raises one event, not a stream
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			clash_q <= 1'b0;
		else
			clash_q <= sync_clash;
	end

	// events: shutdown, capture seen while not armed, sync clash
	always_comb begin
		event_vec             = '0;
		event_vec[EV_SHUT]    = trigger_hit;
		event_vec[EV_IGNORED] = capture_a_ch1 && !trigger_hit;
		event_vec[EV_CLASH]   = sync_clash && !clash_q;
	end

	pcg_irq #(
		.W(NEVT)
	) u_irq (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.event_in (event_vec),
		.clr_wr   (wr_status),
		.mask_wr  (wr_mask),
		.wdata    (bus.wdata[NEVT-1:0]),
		.status   (irq_status),
		.mask     (irq_mask),
		.irq      (irq)
	);

	// read-only view of the effective mode
	always_comb begin
		mode_word      = 8'h00;
		mode_word[1:0] = pair_function_control[FC_CMB_HI:FC_CMB_LO];
		mode_word[2]   = ch3_pwm_on;
		mode_word[3]   = ch4_pwm_on;
		mode_word[4]   = sync_clash;
		if (pcg_decode(mode_word[1:0]) == PCG_NORMAL)
			mode_word[1:0] = 2'b00;
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		next_rdata = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				OFF_FUNC:   next_rdata = pair_function_control;
				OFF_ENABLE: next_rdata = output_master_enable;
				OFF_TRIG:   next_rdata = {3'b111, ext_trigger_off, 4'hF};
				OFF_STATUS: next_rdata = {5'h00, irq_status};
				OFF_MASK:   next_rdata = {5'h00, irq_mask};
				OFF_MODE:   next_rdata = mode_word;
				default:    next_rdata = 8'h00;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rdata <= 8'h00;
		else
			rdata <= next_rdata;
	end

	// mode outputs; the channel timers must already be stopped
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mode_comp  <= 1'b0;
			mode_rsync <= 1'b0;
		end else begin
			mode_comp  <= (cur_mode == PCG_COMP);
			mode_rsync <= (cur_mode == PCG_RSYNC);
		end
	end

	// single pwm bits count only outside the paired modes
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ch3_pwm_on <= 1'b0;
			ch4_pwm_on <= 1'b0;
		end else begin
			ch3_pwm_on <= ch3_single_pwm && !paired;
			ch4_pwm_on <= ch4_single_pwm && !paired;
		end
	end

	// sync bits pass through in every mode
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ch3_sync_on <= 1'b0;
			ch4_sync_on <= 1'b0;
		end else begin
			ch3_sync_on <= ch3_sync_op;
			ch4_sync_on <= ch4_sync_op;
		end
	end

	// buffer selects, ordered ch3 A, ch3 B, ch4 A, ch4 B
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			buffer_on <= 4'h0;
		else
			buffer_on <= pair_function_control[FC_BUF_B4:FC_BUF_A3];
	end

	// six pin gates, gate bit index equals pin index
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			pcg_pin_gate u_gate (
				.mclk    (mclk),
				.reset_n (reset_n),
				.gate    (output_master_enable[gi]),
				.timer   (timer_pin[gi]),
				.gpio    (gpio_pin[gi]),
				.pin_out (pin_out[gi]),
				.pin_oe  (pin_oe[gi])
			);
		end
	endgenerate

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	func_reserved_a: assert property (
		pair_function_control[7:6] == 2'b11)
		else $error("function control reserved bits not one");

	enable_reserved_a: assert property (
		output_master_enable[7:6] == 2'b11)
		else $error("master enable reserved bits not one");

	func_write_a: assert property (
		wr_func && !standby |=>
		pair_function_control[5:0] == $past(bus.wdata[5:0]))
		else $error("function control write lost");

	standby_init_a: assert property (
		standby |=> pair_function_control == RST_FUNC &&
		output_master_enable == RST_ENABLE && ext_trigger_off)
		else $error("standby did not reinitialise registers");

	trigger_clear_a: assert property (
		trigger_hit && !standby |=> output_master_enable[5:0] == 6'h00)
		else $error("trigger did not clear the enables");

	trigger_off_a: assert property (
		capture_a_ch1 && (ext_trigger_off || !paired) &&
		!wr_enable && !standby |=> $stable(output_master_enable))
		else $error("disarmed trigger changed the enables");

	pwm_override_a: assert property (
		paired |=> !ch3_pwm_on && !ch4_pwm_on)
		else $error("single pwm active in paired mode");

	mode_decode_a: assert property (
		pair_function_control[5:4] == 2'b01 |=> !mode_comp && !mode_rsync)
		else $error("combination 01 not treated as normal");

	comp_b_release_a: assert property (
		!output_master_enable[PIN_CMP_B] |=>
		pin_oe[PIN_CMP_B] == $past(gpio_pin[PIN_CMP_B].oe))
		else $error("comp B pin not released to gpio");

	comp_a_release_a: assert property (
		!output_master_enable[PIN_CMP_A] |=>
		pin_oe[PIN_CMP_A] == $past(gpio_pin[PIN_CMP_A].oe))
		else $error("comp A pin not released to gpio");

	ch3_b_drive_a: assert property (
		output_master_enable[PIN_CH3_B] && timer_pin[PIN_CH3_B].oe |=>
		pin_oe[PIN_CH3_B] &&
		pin_out[PIN_CH3_B] == $past(timer_pin[PIN_CH3_B].out))
		else $error("ch3 B pin not driven by the timer");

	buffer_follow_a: assert property (
		wr_func && !standby |=> ##1
		buffer_on == $past(bus.wdata[3:0], 2))
		else $error("buffer selects do not follow the register");

	read_window_a: assert property (
		!bus.rd |=> rdata == 8'h00)
		else $error("read data outside its cycle");

	shutdown_irq_a: assert property (
		trigger_hit && irq_mask[EV_SHUT] && !wr_mask |=> irq)
		else $error("shutdown did not raise the interrupt");

	sync_follow_a: assert property (
		1'b1 |=> ch3_sync_on == $past(ch3_sync_op) &&
		ch4_sync_on == $past(ch4_sync_op))
		else $error("sync bits not passed through");

	comp_select_a: assert property (
		pair_function_control[5:4] == 2'b10 |=> mode_comp && !mode_rsync)
		else $error("complementary mode not selected");

	rsync_select_a: assert property (
		pair_function_control[5:4] == 2'b11 |=> mode_rsync && !mode_comp)
		else $error("reset-synchronized mode not selected");

	ch3_a_release_a: assert property (
		!output_master_enable[PIN_CH3_A] |=>
		pin_oe[PIN_CH3_A] == $past(gpio_pin[PIN_CH3_A].oe))
		else $error("ch3 A pin not released to gpio");

	func_read_a: assert property (
		bus.rd && bus.addr == OFF_FUNC |=>
		rdata == $past(pair_function_control))
		else $error("function control read back wrong");

	// capture that arrives while the trigger is not armed
	ignored_c: cover property (capture_a_ch1 && !trigger_hit);

	comp_mode_c: cover property (
		wr_func && bus.wdata[5:4] == 2'b10 ##1 mode_comp == 1'b0 ##1 mode_comp);

	rsync_mode_c: cover property (mode_rsync && ch3_sync_on);

	shutdown_c: cover property (trigger_hit ##1 pin_oe[PIN_CMP_B] == 1'b0);

	irq_clear_c: cover property (irq ##1 wr_status ##1 !irq);
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the paired channel gate block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pcg_pkg::*;

	logic                mclk;
	logic                reset_n;
	logic                standby;
	pcg_bus_t            bus;
	logic [DATA_W-1:0]   rdata;
	logic                capture_a_ch1;
	logic                ch3_single_pwm;
	logic                ch4_single_pwm;
	logic                ch3_sync_op;
	logic                ch4_sync_op;
	pcg_pin_t [NPIN-1:0] timer_pin;
	pcg_pin_t [NPIN-1:0] gpio_pin;
	logic [NPIN-1:0]     pin_out;
	logic [NPIN-1:0]     pin_oe;
	logic                mode_comp;
	logic                mode_rsync;
	logic                ch3_pwm_on;
	logic                ch4_pwm_on;
	logic                ch3_sync_on;
	logic                ch4_sync_on;
	logic [3:0]          buffer_on;
	logic                irq;
	int                  num_errors;
	int                  tests_run;
	int                  cycles;

	pcg_gate dut (
		.mclk          (mclk),
		.reset_n       (reset_n),
		.standby       (standby),
		.bus           (bus),
		.rdata         (rdata),
		.capture_a_ch1 (capture_a_ch1),
		.ch3_single_pwm(ch3_single_pwm),
		.ch4_single_pwm(ch4_single_pwm),
		.ch3_sync_op   (ch3_sync_op),
		.ch4_sync_op   (ch4_sync_op),
		.timer_pin     (timer_pin),
		.gpio_pin      (gpio_pin),
		.pin_out       (pin_out),
		.pin_oe        (pin_oe),
		.mode_comp     (mode_comp),
		.mode_rsync    (mode_rsync),
		.ch3_pwm_on    (ch3_pwm_on),
		.ch4_pwm_on    (ch4_pwm_on),
		.ch3_sync_on   (ch3_sync_on),
		.ch4_sync_on   (ch4_sync_on),
		.buffer_on     (buffer_on),
		.irq           (irq)
	);

	// 200 MHz clock
	initial mclk = 1'b0;
	always #2.5 mclk = ~mclk;

	task automatic conclude;
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// cut a hang short; the whole run needs well under a thousand cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			$display("MISMATCH at %0t: timeout", $time);
			conclude();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// wait n edges, then let their updates land
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= {1'b1, 1'b0, a, d};
		@(posedge mclk);
		bus <= '0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		bus <= {1'b0, 1'b1, a, 8'h00};
		@(posedge mclk);
		bus <= '0;
		#1 chk(rdata, exp);
	endtask

	task automatic pulse_capture;
		@(posedge mclk);
		capture_a_ch1 <= 1'b1;
		@(posedge mclk);
		capture_a_ch1 <= 1'b0;
		tick(1);
	endtask

	task automatic t_reset;
		rd_chk(OFF_FUNC, RST_FUNC);
		rd_chk(OFF_ENABLE, RST_ENABLE);
		rd_chk(OFF_TRIG, 8'hFF);
		rd_chk(OFF_STATUS, 8'h00);
		rd_chk(OFF_MASK, 8'h00);
		rd_chk(8'h18, 8'h00);
		chk(pin_oe, 8'h3F);
		chk(irq, 1'b0);
	endtask

	task automatic t_func;
		wr(OFF_FUNC, 8'h0A);
		rd_chk(OFF_FUNC, 8'hCA);
		chk(buffer_on, 4'hA);
		wr(OFF_FUNC, 8'h05);
		rd_chk(OFF_FUNC, 8'hC5);
		chk(buffer_on, 4'h5);
		// no counters run here, so a paired mode may be chosen
		for (int c = 0; c < 4; c++) begin
			wr(OFF_FUNC, {2'b00, c[1:0], 4'h0});
			// both sync bits only outside complementary mode
			ch4_sync_op <= (c == 3);
			rd_chk(OFF_FUNC, {2'b11, c[1:0], 4'h0});
			rd_chk(OFF_MODE, (c < 2) ? 8'h0C : 8'(c));
			chk(mode_comp, c == 2);
			chk(mode_rsync, c == 3);
			chk(ch3_pwm_on, c < 2);
			chk(ch4_pwm_on, c < 2);
			chk(ch3_sync_on, 1'b1);
			chk(ch4_sync_on, c == 3);
		end
		// drop the second sync bit before complementary mode returns
		@(posedge mclk);
		ch4_sync_op <= 1'b0;
	endtask

	task automatic t_gate;
		for (int i = 0; i < NPIN; i++) begin
			wr(OFF_ENABLE, 8'h01 << i);
			tick(1);
			chk(pin_oe, 8'h01 << i);
			chk(pin_out, 8'h01 << i);
		end
		wr(OFF_ENABLE, 8'h00);
		rd_chk(OFF_ENABLE, 8'hC0);
	endtask

	task automatic t_trigger;
		wr(OFF_FUNC, 8'h20);
		wr(OFF_ENABLE, 8'hFF);
		wr(OFF_MASK, 8'h01);
		wr(OFF_TRIG, 8'hEF);
		rd_chk(OFF_TRIG, 8'hEF);
		pulse_capture();
		chk(pin_oe, 8'h00);
		chk(irq, 1'b1);
		rd_chk(OFF_ENABLE, 8'hC0);
		rd_chk(OFF_STATUS, 8'h01);
		wr(OFF_STATUS, 8'h01);
		tick(1);
		chk(irq, 1'b0);
		// reset-synchronized mode uses the same trigger
		wr(OFF_FUNC, 8'h30);
		wr(OFF_ENABLE, 8'hFF);
		pulse_capture();
		rd_chk(OFF_ENABLE, 8'hC0);
		// software set in the same cycle as the hardware clear
		@(posedge mclk);
		bus <= {1'b1, 1'b0, OFF_ENABLE, 8'hFF};
		capture_a_ch1 <= 1'b1;
		@(posedge mclk);
		bus <= '0;
		capture_a_ch1 <= 1'b0;
		rd_chk(OFF_ENABLE, 8'hC0);
		wr(OFF_STATUS, 8'h07);
	endtask

	task automatic t_ignored;
		wr(OFF_ENABLE, 8'hFF);
		wr(OFF_TRIG, 8'hFF);
		pulse_capture();
		rd_chk(OFF_ENABLE, 8'hFF);
		wr(OFF_TRIG, 8'hEF);
		wr(OFF_FUNC, 8'h10);
		pulse_capture();
		rd_chk(OFF_ENABLE, 8'hFF);
		rd_chk(OFF_STATUS, 8'h02);
		chk(irq, 1'b0);
		// unmasking a pending event raises the line
		wr(OFF_MASK, 8'h02);
		tick(1);
		chk(irq, 1'b1);
		wr(OFF_STATUS, 8'h02);
		tick(1);
		chk(irq, 1'b0);
	endtask

	task automatic t_standby;
		wr(OFF_FUNC, 8'h25);
		wr(OFF_ENABLE, 8'h00);
		@(posedge mclk);
		standby <= 1'b1;
		@(posedge mclk);
		standby <= 1'b0;
		rd_chk(OFF_FUNC, RST_FUNC);
		rd_chk(OFF_ENABLE, RST_ENABLE);
		rd_chk(OFF_TRIG, 8'hFF);
	endtask

	// every input settles at time zero; reset spans 20 cycles
	initial begin
		num_errors = 0;
		tests_run = 0;
		cycles = 0;
		reset_n = 1'b0;
		standby = 1'b0;
		bus = '0;
		capture_a_ch1 = 1'b0;
		ch3_single_pwm = 1'b1;
		ch4_single_pwm = 1'b1;
		ch3_sync_op = 1'b1;
		ch4_sync_op = 1'b0; // never both sync bits in comp mode
		timer_pin = '1;
		gpio_pin = '0;
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset();
		t_func();
		t_gate();
		t_trigger();
		t_ignored();
		t_standby();
		conclude();
	end
endmodule
`default_nettype wire
